//--- rtl/bda_map.sv
// bda_map: maps an 8-bit direct operand to a 12-bit data address
// assumes: purely combinational, instantiated once in the select block and shared by read and write
`timescale 1ns/1ps
`default_nettype none
module bda_map (
    input  wire logic       i_acc_sel_n,                     // 0 forces the access bank
    input  wire logic [3:0] i_bank,                          // bank select low bits
    input  wire logic [7:0] i_offset,                        // in-bank offset
    output logic      [11:0] o_addr                          // resolved data address
);
    // access bank joins low bank 0 and high bank 15 contiguously
    always_comb begin
        if (!i_acc_sel_n) begin
            if (i_offset <= bda_pkg::ACC_LOW_LAST)
                o_addr = {bda_pkg::ACC_LOW_BANK, i_offset};
            else
                o_addr = {bda_pkg::ACC_HIGH_BANK, i_offset};
        end else begin
            o_addr = {i_bank, i_offset};
        end
    end
endmodule
`default_nettype wire

//--- rtl/bda_pkg.sv
// bda_pkg: constants and carrier types for the banked data address select block
// assumes: included before any module of the block; nothing is imported from it
package bda_pkg;
    localparam int          ADDR_W         = 12;             // data address width
    localparam int          OFFS_W         = 8;              // in-bank offset width
    localparam int          BANK_W         = 4;              // bank number width
    localparam int          NUM_BANKS      = 16;             // banks in data space
    localparam logic [7:0]  ACC_LOW_LAST   = 8'h5F;          // last access-ram-low offset
    localparam logic [3:0]  ACC_LOW_BANK   = 4'h0;           // bank holding access ram low
    localparam logic [3:0]  ACC_HIGH_BANK  = 4'hF;           // bank holding special regs
    localparam logic [7:0]  BANK_SEL_RESET = 8'h00;          // bank select value after reset
    localparam logic [7:0]  BANK_SEL_MASK  = 8'h0F;          // implemented bank select bits
    localparam logic [15:0] IMPL_BANKS     = 16'hFFFF;       // default implemented-bank map

    // operation requested by the core for one data access
    typedef enum logic [1:0] {
        BDA_OP_DIRECT,                                       // banked / access direct access
        BDA_OP_FILE_MOVE,                                    // full 12-bit source/destination
        BDA_OP_LIT_BANK,                                     // load bank select from literal
        BDA_OP_NONE
    } bda_op_t;

    // one access request from decode
    typedef struct packed {
        bda_op_t     op;                                     // operation kind
        logic        acc_sel_n;                              // 0 forces the access bank
        logic [7:0]  offset;                                 // in-bank offset / literal
        logic [11:0] src_full;                               // file move source address
        logic [11:0] dst_full;                               // file move destination address
        logic        rd;                                     // read requested
        logic        wr;                                     // write requested
    } bda_req_t;

    // resolved access toward the data memory
    typedef struct packed {
        logic [11:0] rd_addr;                                // read address
        logic [11:0] wr_addr;                                // write address
        logic        rd_en;                                  // read strobe to memory
        logic        wr_en;                                  // write strobe to memory
        logic        rd_zero;                                // read hits unimplemented bank
    } bda_mem_t;
endpackage

//--- rtl/bda_select.sv
// bda_select: direct-address formation and bank select register for the data space
// assumes: core decode presents one request per cycle; data memory sits outside
`timescale 1ns/1ps
`default_nettype none
module bda_select #(
    parameter logic [15:0] IMPL_BANKS = bda_pkg::IMPL_BANKS  // one bit per implemented bank
) (
    input  wire logic             i_mclk,                    // core clock
    input  wire logic             i_rstn,                    // synchronous reset, active low
    input  wire bda_pkg::bda_req_t i_req,                    // request from decode
    input  wire logic             i_bsel_wr,                 // direct write of bank select
    input  wire logic [7:0]       i_bsel_wdata,              // bank select write data
    input  wire logic [7:0]       i_mem_rdata,               // read data from data memory
    output bda_pkg::bda_mem_t     o_mem,                     // registered memory access
    output logic [7:0]            o_rdata,                   // read data after zero gating
    output logic                  o_flags_upd,               // status flags may update
    output logic [7:0]            o_bank_select_reg          // bank select read value
);
    // bank select state and its next value
    logic [7:0]  bank_select_r;                              // implemented low nibble held
    logic [7:0]  bank_select_nxt;                            // next bank select value

    // direct operand resolved through the access-bank map
    logic [11:0] dir_addr;                                   // banked or access address

    // request kind decode
    logic        op_direct;                                  // direct banked or access access
    logic        op_lit;                                     // literal load of bank select
    logic        req_any;                                    // direct read or write present

    // implemented-bank lookups, one per address that can reach memory
    logic        dir_impl;                                   // direct target bank exists
    logic        src_impl;                                   // move source bank exists
    logic        dst_impl;                                   // move destination bank exists

    // memory access and status pulse next values
    logic [11:0] rd_addr_nxt;                                // next read address
    logic [11:0] wr_addr_nxt;                                // next write address
    logic        rd_en_nxt;                                  // next read strobe
    logic        wr_en_nxt;                                  // next write strobe
    logic        rd_zero_nxt;                                // next absent-bank read marker
    logic        flags_upd_nxt;                              // next status-update pulse

    // read return pipeline and bank select view
    logic        rd_absent_r;                                // absent-bank read, zero due
    logic        rd_live_r;                                  // real read, memory data due
    logic [7:0]  rdata_nxt;                                  // next read result
    logic [7:0]  bsel_view_nxt;                              // next bank select read view

    // operand to address map shared by the banked and access paths
    bda_map u_map (
        .i_acc_sel_n (i_req.acc_sel_n),
        .i_bank      (bank_select_r[3:0]),
        .i_offset    (i_req.offset),
        .o_addr      (dir_addr)
    );

    // request kind decode
    always_comb begin
        op_direct = (i_req.op == bda_pkg::BDA_OP_DIRECT);
        op_lit    = (i_req.op == bda_pkg::BDA_OP_LIT_BANK);
        req_any   = op_direct & (i_req.rd | i_req.wr);
    end

    // implemented-bank lookups: the upper nibble of an address picks one map bit
    always_comb begin
        dir_impl = IMPL_BANKS[dir_addr[11:8]];
        src_impl = IMPL_BANKS[i_req.src_full[11:8]];
        dst_impl = IMPL_BANKS[i_req.dst_full[11:8]];
    end

    // bank select next value: a literal load wins over a direct register write
    always_comb begin
        bank_select_nxt = bank_select_r;
        if (op_lit) begin
            bank_select_nxt = i_req.offset & bda_pkg::BANK_SEL_MASK;
        end else if (i_bsel_wr) begin
            bank_select_nxt = i_bsel_wdata & bda_pkg::BANK_SEL_MASK;
        end
    end

    // bank select register
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            bank_select_r <= bda_pkg::BANK_SEL_RESET;
        end else begin
            bank_select_r <= bank_select_nxt;
        end
    end

    // next addresses: held between requests so memory sees a steady bus
    always_comb begin
        rd_addr_nxt = o_mem.rd_addr;
        wr_addr_nxt = o_mem.wr_addr;
        unique case (i_req.op)
            bda_pkg::BDA_OP_DIRECT: begin
                rd_addr_nxt = dir_addr;
                wr_addr_nxt = dir_addr;
            end
            bda_pkg::BDA_OP_FILE_MOVE: begin
                rd_addr_nxt = i_req.src_full;
                wr_addr_nxt = i_req.dst_full;
            end
            bda_pkg::BDA_OP_LIT_BANK: begin
                rd_addr_nxt = o_mem.rd_addr;                 // no data access
            end
            bda_pkg::BDA_OP_NONE: begin
                rd_addr_nxt = o_mem.rd_addr;                 // idle cycle
            end
        endcase
    end

    // next strobes: one-cycle pulses, only toward a bank that is implemented
    always_comb begin
        rd_en_nxt   = 1'b0;
        wr_en_nxt   = 1'b0;
        rd_zero_nxt = 1'b0;
        unique case (i_req.op)
            bda_pkg::BDA_OP_DIRECT: begin
                rd_en_nxt   = i_req.rd & dir_impl;
                wr_en_nxt   = i_req.wr & dir_impl;
                rd_zero_nxt = i_req.rd & ~dir_impl;
            end
            bda_pkg::BDA_OP_FILE_MOVE: begin
                rd_en_nxt   = i_req.rd & src_impl;
                wr_en_nxt   = i_req.wr & dst_impl;
                rd_zero_nxt = i_req.rd & ~src_impl;
            end
            bda_pkg::BDA_OP_LIT_BANK: begin
                rd_en_nxt   = 1'b0;                          // no data access
            end
            bda_pkg::BDA_OP_NONE: begin
                rd_en_nxt   = 1'b0;                          // idle cycle
            end
        endcase
    end

    // memory access register; every output leaves straight from a flip-flop
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_mem <= '0;
        end else begin
            o_mem.rd_addr <= rd_addr_nxt;
            o_mem.wr_addr <= wr_addr_nxt;
            o_mem.rd_en   <= rd_en_nxt;
            o_mem.wr_en   <= wr_en_nxt;
            o_mem.rd_zero <= rd_zero_nxt;
        end
    end

    // status-update pulse: a direct access updates flags even toward an absent bank
    always_comb begin
        flags_upd_nxt = req_any;
    end

    // status-update pulse register
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_flags_upd <= 1'b0;
        end else begin
            o_flags_upd <= flags_upd_nxt;
        end
    end

    // absent-bank read marker: memory is never read, so the result is forced to zero
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            rd_absent_r <= 1'b0;
        end else begin
            rd_absent_r <= o_mem.rd_zero;
        end
    end

    // live read marker: memory answers one edge after the strobe
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            rd_live_r <= 1'b0;
        end else begin
            rd_live_r <= o_mem.rd_en;
        end
    end

    // next read result: zero for an absent bank, memory data for a live read, else hold
    always_comb begin
        rdata_nxt = o_rdata;
        if (rd_absent_r) begin
            rdata_nxt = 8'h00;
        end else if (rd_live_r) begin
            rdata_nxt = i_mem_rdata;
        end
    end

    // read result register
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rdata <= 8'h00;
        end else begin
            o_rdata <= rdata_nxt;
        end
    end

    // bank select read view next value: upper nibble always reads zero
    always_comb begin
        bsel_view_nxt = bank_select_r & bda_pkg::BANK_SEL_MASK;
    end

    // bank select read view register
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_bank_select_reg <= bda_pkg::BANK_SEL_RESET;
        end else begin
            o_bank_select_reg <= bsel_view_nxt;
        end
    end
endmodule
`default_nettype wire

//--- test/bda_mem_model.sv
// bda_mem_model: behavioural data memory behind the select block
// assumes: reads answered one cycle after the read strobe
`timescale 1ns/1ps
`default_nettype none
module bda_mem_model (
    input  wire logic              i_mclk,  // core clock
    input  wire bda_pkg::bda_mem_t i_mem,   // access from select block
    output logic [7:0]             o_rdata  // read data
);
    // answer with an address pattern; scramble the idle bus so no stale value passes
    always_ff @(posedge i_mclk) begin
        o_rdata <= i_mem.rd_en ? (i_mem.rd_addr[7:0] ^ {2{i_mem.rd_addr[11:8]}}) : ~o_rdata;
    end
endmodule
`default_nettype wire

//--- test/bda_select_assertions.sv
// bda_select_assertions: port timing checks for the bank select block
// assumes: bound to bda_select, single clock domain
`timescale 1ns/1ps
`default_nettype none
module bda_select_assertions #(
    parameter logic [15:0] IMPL_BANKS = 16'hFFFF  // bank map
) (
    input wire logic              i_mclk,            // clock
    input wire logic              i_rstn,            // reset
    input wire bda_pkg::bda_req_t i_req,             // request
    input wire logic              i_bsel_wr,         // bank write
    input wire logic [7:0]        i_bsel_wdata,      // bank data
    input wire logic [7:0]        i_mem_rdata,       // memory data
    input wire bda_pkg::bda_mem_t o_mem,             // access
    input wire logic [7:0]        o_rdata,           // read result
    input wire logic              o_flags_upd,       // flag pulse
    input wire logic [7:0]        o_bank_select_reg  // bank select
);
    // request decode helpers
    wire logic dir = i_req.op == bda_pkg::BDA_OP_DIRECT;
    wire logic lit = i_req.op == bda_pkg::BDA_OP_LIT_BANK;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    // a direct read request, in its banked and its access-bank form
    sequence s_rd; dir && i_req.rd; endsequence
    sequence s_rd_bank; s_rd ##0 i_req.acc_sel_n; endsequence
    sequence s_rd_acc; s_rd ##0 !i_req.acc_sel_n; endsequence
    // an absent-bank read leaving toward memory
    sequence s_abs_rd; o_mem.rd_zero; endsequence
    property p_lit;
        lit |-> ##2 o_bank_select_reg == {4'h0, $past(i_req.offset[3:0], 2)};
    endproperty
    property p_bwr;
        i_bsel_wr && !lit |-> ##2 o_bank_select_reg == {4'h0, $past(i_bsel_wdata[3:0], 2)};
    endproperty
    property p_bank;
        s_rd_bank |=> o_mem.rd_addr == {o_bank_select_reg[3:0], $past(i_req.offset)};
    endproperty
    property p_acc;
        s_rd_acc |=> o_mem.rd_addr == {(($past(i_req.offset) > bda_pkg::ACC_LOW_LAST) ?
            bda_pkg::ACC_HIGH_BANK : bda_pkg::ACC_LOW_BANK), $past(i_req.offset)};
    endproperty
    property p_move;
        i_req.op == bda_pkg::BDA_OP_FILE_MOVE |=>
            o_mem.rd_addr == $past(i_req.src_full) && o_mem.wr_addr == $past(i_req.dst_full);
    endproperty
    property p_flag; dir && (i_req.rd || i_req.wr) |=> o_flags_upd; endproperty
    property p_impl; o_mem.wr_en |-> IMPL_BANKS[o_mem.wr_addr[11:8]]; endproperty
    property p_zero; s_abs_rd |-> ##2 o_rdata == 8'h00; endproperty
    a_lit: assert property (p_lit) else $error("bank literal load wrong");
    a_bwr: assert property (p_bwr) else $error("bank write wrong");
    a_bank: assert property (p_bank) else $error("banked address wrong");
    a_acc: assert property (p_acc) else $error("access address wrong");
    a_move: assert property (p_move) else $error("file move address wrong");
    a_flag: assert property (p_flag) else $error("flag pulse missing");
    a_impl: assert property (p_impl) else $error("write to absent bank");
    a_zero: assert property (p_zero) else $error("absent bank read not zero");
endmodule
bind bda_select bda_select_assertions #(.IMPL_BANKS(IMPL_BANKS)) u_chk (.i_mclk(i_mclk),
    .i_rstn(i_rstn), .i_req(i_req), .i_bsel_wr(i_bsel_wr), .i_bsel_wdata(i_bsel_wdata),
    .i_mem_rdata(i_mem_rdata), .o_mem(o_mem), .o_rdata(o_rdata), .o_flags_upd(o_flags_upd),
    .o_bank_select_reg(o_bank_select_reg));
`default_nettype wire

//--- test/bda_select_test.sv
// bda_select_test: directed tests of the bank select block with a memory model
// assumes: checker bound from its own file
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin err_total++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); end end
module bda_select_test;
    localparam logic [15:0] IMPL = 16'h80FF;  // banks 0-7 and 15 present
    localparam bda_pkg::bda_req_t IDLE = '{op: bda_pkg::BDA_OP_NONE, default: '0};
    logic mclk = 1'b0, rstn = 1'b0, bwr = 1'b0, flags;
    logic [7:0] bdat = 8'h00, mq, rdata, bsel;
    bda_pkg::bda_req_t req = IDLE;
    bda_pkg::bda_mem_t mem;
    int err_total = 0, n_compared = 0;
    bda_select #(.IMPL_BANKS(IMPL)) dut (.i_mclk(mclk), .i_rstn(rstn), .i_req(req),
        .i_bsel_wr(bwr), .i_bsel_wdata(bdat), .i_mem_rdata(mq), .o_mem(mem),
        .o_rdata(rdata), .o_flags_upd(flags), .o_bank_select_reg(bsel));
    bda_mem_model u_mem (.i_mclk(mclk), .i_mem(mem), .o_rdata(mq));
    initial forever #10 mclk = ~mclk;
    // one request for one cycle, then idle
    task automatic issue(input bda_pkg::bda_op_t op, input logic acc, input logic [7:0] off,
                         input logic rd, input logic wr);
        @(posedge mclk) req <= '{op, acc, off, 12'h123, 12'h456, rd, wr};
        @(posedge mclk) req <= IDLE;
    endtask
    // direct read, result judged when the read data lands
    task automatic rd_chk(input logic acc, input logic [7:0] off, input logic [7:0] exp);
        issue(bda_pkg::BDA_OP_DIRECT, acc, off, 1'b1, 1'b0);
        repeat (2) @(posedge mclk);
        #1 `CHK(rdata, exp)
    endtask
    task automatic t_banks;
        for (int b = 0; b < 16; b++) begin
            issue(bda_pkg::BDA_OP_LIT_BANK, 1'b1, {4'hA, b[3:0]}, 1'b0, 1'b0);
            rd_chk(1'b1, 8'h3C, IMPL[b] ? 8'h3C ^ {2{b[3:0]}} : 8'h00);
            `CHK(bsel, {4'h0, b[3:0]})
        end
        $display("t_banks done");
    endtask
    task automatic t_access;
        logic [7:0] off;
        @(posedge mclk) {bwr, bdat} <= {1'b1, 8'hF3};
        @(posedge mclk) bwr <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            off = 8'h5F + 8'(i);
            rd_chk(1'b0, off, (i > 0) ? (off ^ 8'hFF) : off);
        end
        rd_chk(1'b0, 8'hFF, 8'hFF ^ 8'hFF);
        `CHK(bsel, 8'h03)
        $display("t_access done");
    endtask
    task automatic t_move_unimpl;
        issue(bda_pkg::BDA_OP_FILE_MOVE, 1'b1, 8'h00, 1'b1, 1'b1);
        #1 `CHK({mem.rd_addr, mem.wr_addr}, 24'h123456)
        issue(bda_pkg::BDA_OP_LIT_BANK, 1'b1, 8'h09, 1'b0, 1'b0);
        issue(bda_pkg::BDA_OP_DIRECT, 1'b1, 8'h10, 1'b0, 1'b1);
        #1 `CHK({mem.wr_en, flags}, 2'b01)
        $display("t_move_unimpl done");
    endtask
    // mid-run reset: outputs clear, and a request right after release works
    task automatic t_reset;
        issue(bda_pkg::BDA_OP_LIT_BANK, 1'b1, 8'h05, 1'b0, 1'b0);
        rd_chk(1'b1, 8'h21, 8'h21 ^ 8'h55);
        @(posedge mclk) rstn <= 1'b0;
        repeat (2) @(posedge mclk);
        #1 `CHK({bsel, rdata, flags, mem.rd_en, mem.wr_en}, 19'h00000)
        @(posedge mclk) rstn <= 1'b1;
        @(posedge mclk) #1 `CHK(bsel, 8'h00)
        rd_chk(1'b1, 8'h21, 8'h21);
        $display("t_reset done");
    endtask
    task automatic test_done;
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (16) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk) #1 `CHK(bsel, 8'h00)
        t_banks;
        t_access;
        t_move_unimpl;
        t_reset;
        test_done;
    end
    // watchdog
    initial begin
        repeat (3000) @(posedge mclk);
        err_total++;
        test_done;
    end
endmodule
`default_nettype wire
